// [verilog/sea_pkg.sv]
// constants shared by the status event aggregator and its jitter detector
// assumes one configuration clock domain with 8-bit register addressing
package sea_pkg;
  // register addresses on the configuration port
  localparam logic [7:0] ADDR_JITTER_TH  = 8'hFC;  // jitter_count_threshold
  localparam logic [7:0] ADDR_IRQ_MASK   = 8'hFD;  // irq_enable_mask
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'hFE;  // irq_flag_status
  // flag and mask bit positions
  localparam int BIT_MODE   = 0;  // video mode change
  localparam int BIT_AUTO   = 1;  // auto-adjust done
  localparam int BIT_FIFO   = 2;  // decoupling buffer overflow
  localparam int BIT_OSD    = 3;  // overlay sequence end
  localparam int BIT_OIF    = 4;  // output underflow
  localparam int BIT_IIF    = 5;  // hsync jitter
  localparam int FLAG_COUNT = 6;  // number of event flags
  localparam int MODE_CAUSES = 4; // toggle, value change, vsync jitter, hsync jitter
  // values after reset
  localparam logic [5:0] FLAGS_RESET  = 6'h00;
  localparam logic [5:0] MASK_RESET   = 6'h00;
  localparam logic [7:0] JITTER_TH_RESET = 8'h00;
  localparam logic [3:0] MODE_EN_RESET   = 4'h0;
  // width of the low line-length bits compared by the jitter detector
  localparam int LINE_LOW_BITS = 2;
endpackage

// [verilog/sea_jitter_detect.sv]
// hsync jitter detector: counts line-length mismatches within a frame
// assumes hsync and vsync arrive as one-cycle pulses on mclk, the sample clock
`timescale 1ns/1ps
module sea_jitter_detect
  import sea_pkg::*;
#(
  parameter int CNT_W = 8  // width of the per-frame mismatch counter
)
(
  input  wire logic             mclk,
  input  wire logic             nrst,
  input  wire logic             hsyncPulse,   // start of a line
  input  wire logic             vsyncPulse,   // start of a frame
  input  wire logic             inWindow,     // inside the sampled area
  input  wire logic             detectAll,    // reset or input interface off
  input  wire logic [CNT_W-1:0] threshold,    // mismatches allowed per frame
  output logic                  jitterEvent   // level, high while over threshold
);
  import sea_pkg::*;

  // elaboration check: a zero-width or oversized counter cannot be built
  if (CNT_W < 1 || CNT_W > 16)
  begin : g_badCntW
    $error("sea_jitter_detect: CNT_W out of range");
  end

  logic [LINE_LOW_BITS-1:0] lenCnt_q, lenCnt_d;    // low bits of running line length
  logic [LINE_LOW_BITS-1:0] prevLen_q, prevLen_d;  // low bits of previous line
  logic                     havePrev_q, havePrev_d; // previous length valid
  logic [CNT_W-1:0]         diffCnt_q, diffCnt_d;  // mismatches this frame
  logic                     event_q, event_d;      // registered level output
  logic                     active;                // detection allowed now

  // window gating: sample clock drifts during vsync, so only watch the picture
  assign active = inWindow | detectAll;

  // next-state logic of the detector
  always_comb
  begin
    lenCnt_d   = lenCnt_q + 1'h1;   // wraps, only low bits matter
    prevLen_d  = prevLen_q;
    havePrev_d = havePrev_q;
    diffCnt_d  = diffCnt_q;
    if (vsyncPulse)
    begin
      // new frame: accumulation restarts
      diffCnt_d  = '0;                                          // R11
      havePrev_d = 1'h0;
      lenCnt_d   = '0;
    end
    else if (hsyncPulse)
    begin
      // line end: compare the two low bits with the previous line
      prevLen_d  = lenCnt_q;
      havePrev_d = 1'h1;
      lenCnt_d   = '0;
      if (havePrev_q && active && (lenCnt_q != prevLen_q) && (diffCnt_q != '1))
        diffCnt_d = diffCnt_q + 1'h1;                           // R11
    end
    // level: stays high until the next vsync clears the count
    event_d = (diffCnt_d > threshold);                          // R7
  end

  // registers only
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      lenCnt_q   <= '0;
      prevLen_q  <= '0;
      havePrev_q <= 1'h0;
      diffCnt_q  <= '0;
      event_q    <= 1'h0;
    end
    else
    begin
      lenCnt_q   <= lenCnt_d;
      prevLen_q  <= prevLen_d;
      havePrev_q <= havePrev_d;
      diffCnt_q  <= diffCnt_d;
      event_q    <= event_d;
    end
  end

  assign jitterEvent = event_q;

  // a new frame always starts with an empty mismatch count
  property p_frameClear;
    @(posedge mclk) disable iff (!nrst)
    vsyncPulse |=> (diffCnt_q == '0) && !event_q;
  endproperty
  a_frameClear: assert property (p_frameClear) else $error("mismatch count not cleared at vsync"); // R11

  // a mismatching line inside the window adds exactly one
  property p_countMismatch;
    @(posedge mclk) disable iff (!nrst)
    (hsyncPulse && !vsyncPulse && havePrev_q && active && (lenCnt_q != prevLen_q) && (diffCnt_q != '1))
      |=> (diffCnt_q == $past(diffCnt_q) + 1'h1);
  endproperty
  a_countMismatch: assert property (p_countMismatch) else $error("line mismatch not counted"); // R11
endmodule

// [verilog/sea_status_event_aggregator.sv]
// status event aggregator: six sticky event flags, a mask and an active-low interrupt pin
// assumes event inputs are synchronous to mclk and the configuration port is driven
// by the serial configuration slave in the same clock domain
//
// Overview of operation
// R1: pin low while any flag is high
// R2: mode flag from enabled mode-detection causes
// R3: auto flag set when measurement completes
// R4: fifo flag set when buffer becomes full
// R5: osd flag set at animation sequence end
// R6: oif flag set when output stream breaks
// R7: iif flag set when jitter exceeds threshold
// R8: flags readable at status address FEH
// R9: flags clear only by writing one
// R10: mask at FDH, one enables a condition
// R11: jitter from low two bits per frame
// R12: masked conditions ignored; reset clears flags, mask
`timescale 1ns/1ps
module sea_status_event_aggregator
  import sea_pkg::*;
#(
  parameter int JIT_CNT_W = 8  // width of the jitter threshold and counter
)
(
  input  wire logic                          mclk,
  input  wire logic                          nrst,
  // configuration register port
  input  wire logic [7:0]                    cfgAddr,
  input  wire logic                          cfgWrEn,
  input  wire logic [7:0]                    cfgWrData,
  output logic      [7:0]                    cfgRdData,
  // mode detection causes and their enables
  input  wire logic [sea_pkg::MODE_CAUSES-1:0] modeCause,
  input  wire logic [sea_pkg::MODE_CAUSES-1:0] modeCauseEn,
  // other sub-unit events
  input  wire logic                          autoDone,
  input  wire logic                          bufferFull,
  input  wire logic                          osdSeqEnd,
  input  wire logic                          oifBreak,
  // hsync jitter detection inputs
  input  wire logic                          hsyncPulse,
  input  wire logic                          vsyncPulse,
  input  wire logic                          inWindow,
  input  wire logic                          detectAll,
  // host interrupt pin, active low
  output logic                               irqN
);
  import sea_pkg::*;

  // elaboration check: the threshold must fit in one 8-bit register
  if (JIT_CNT_W < 1 || JIT_CNT_W > 8)
  begin : g_badJitW
    $error("sea_status_event_aggregator: JIT_CNT_W must be 1 to 8");
  end

  // register state
  logic [FLAG_COUNT-1:0] flags_q, flags_d;        // sticky event flags
  logic [FLAG_COUNT-1:0] mask_q, mask_d;          // condition enables
  logic [JIT_CNT_W-1:0]  jitterTh_q, jitterTh_d;  // jitter_count_threshold
  logic [7:0]            rdData_q, rdData_d;      // registered read answer
  logic                  irqN_q, irqN_d;          // registered pin level

  // decoded accesses and raw conditions
  logic                  wrStatus;                // write to status register
  logic                  wrMask;                  // write to mask register
  logic                  wrJitter;                // write to threshold register
  logic [FLAG_COUNT-1:0] cond;                    // raw conditions per flag
  logic [FLAG_COUNT-1:0] setVec;                  // masked set requests
  logic [FLAG_COUNT-1:0] clrVec;                  // write-one-to-clear requests
  logic                  jitterEvent;             // from the jitter detector

  // address decode, one cycle strobe per write
  assign wrStatus = cfgWrEn && (cfgAddr == ADDR_IRQ_STATUS);
  assign wrMask   = cfgWrEn && (cfgAddr == ADDR_IRQ_MASK);
  assign wrJitter = cfgWrEn && (cfgAddr == ADDR_JITTER_TH);

  // jitter detector feeding the iif condition
  sea_jitter_detect #(
    .CNT_W       (JIT_CNT_W)
  ) sea_jitter_detect_i (
    .mclk        (mclk),
    .nrst        (nrst),
    .hsyncPulse  (hsyncPulse),
    .vsyncPulse  (vsyncPulse),
    .inWindow    (inWindow),
    .detectAll   (detectAll),
    .threshold   (jitterTh_q),
    .jitterEvent (jitterEvent)
  );

  // gather raw conditions into one vector
  always_comb
  begin
    cond = '0;
    cond[BIT_MODE] = |(modeCause & modeCauseEn);  // R2
    cond[BIT_AUTO] = autoDone;                    // R3
    cond[BIT_FIFO] = bufferFull;                  // R4
    cond[BIT_OSD]  = osdSeqEnd;                   // R5
    cond[BIT_OIF]  = oifBreak;                    // R6
    cond[BIT_IIF]  = jitterEvent;                 // R7
  end

  // per-bit set and clear terms, one generate loop over flags
  genvar gi;
  generate
    for (gi = 0; gi < FLAG_COUNT; gi++)
    begin : g_flag
      // masked condition never reaches its flag
      assign setVec[gi] = cond[gi] & mask_q[gi];          // R10 R12
      // writing zero leaves the bit alone
      assign clrVec[gi] = wrStatus & cfgWrData[gi];       // R9
    end
  endgenerate

  // next values of flags, mask and threshold
  always_comb
  begin
    // set beats clear so an event in the clearing cycle is kept
    flags_d    = (flags_q & ~clrVec) | setVec;            // R9
    mask_d     = mask_q;
    jitterTh_d = jitterTh_q;
    if (wrMask)
      mask_d = cfgWrData[FLAG_COUNT-1:0];                 // R10
    if (wrJitter)
      jitterTh_d = cfgWrData[JIT_CNT_W-1:0];
  end

  // next read answer; unmapped addresses read zero
  always_comb
  begin
    rdData_d = 8'h00;
    case (cfgAddr)
      ADDR_IRQ_STATUS: rdData_d[FLAG_COUNT-1:0] = flags_q;  // R8
      ADDR_IRQ_MASK:   rdData_d[FLAG_COUNT-1:0] = mask_q;
      ADDR_JITTER_TH:  rdData_d[JIT_CNT_W-1:0]  = jitterTh_q;
      default:         rdData_d = 8'h00;
    endcase
  end

  // pin follows the next flag value so it drops with the flag, no extra lag
  always_comb
  begin
    irqN_d = ~(|flags_d);                                 // R1
  end

  // registers only
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      flags_q    <= FLAGS_RESET;                          // R12
      mask_q     <= MASK_RESET;                           // R12
      jitterTh_q <= JITTER_TH_RESET[JIT_CNT_W-1:0];
      rdData_q   <= 8'h00;
      irqN_q     <= 1'h1;
    end
    else
    begin
      flags_q    <= flags_d;
      mask_q     <= mask_d;
      jitterTh_q <= jitterTh_d;
      rdData_q   <= rdData_d;
      irqN_q     <= irqN_d;
    end
  end

  assign cfgRdData = rdData_q;
  assign irqN      = irqN_q;

  // named sequences for the status write and clear steps
  sequence s_statusWriteOnes(int b);
    wrStatus && cfgWrData[b];
  endsequence

  sequence s_noClear(int b);
    !(wrStatus && cfgWrData[b]);
  endsequence

  // pin low whenever some flag is high
  property p_pinLow;
    @(posedge mclk) disable iff (!nrst)
    (flags_q != '0) |-> !irqN;
  endproperty
  a_pinLow: assert property (p_pinLow) else $error("irq pin high with a flag set"); // R1

  // pin released once every flag is low
  property p_pinHigh;
    @(posedge mclk) disable iff (!nrst)
    (flags_q == '0) |-> irqN;
  endproperty
  a_pinHigh: assert property (p_pinHigh) else $error("irq pin low with no flag set"); // R1

  // enabled mode cause sets the mode flag next cycle
  property p_modeSet;
    @(posedge mclk) disable iff (!nrst)
    (mask_q[BIT_MODE] && |(modeCause & modeCauseEn)) |=> flags_q[BIT_MODE];
  endproperty
  a_modeSet: assert property (p_modeSet) else $error("mode flag not set"); // R2

  // auto-adjust completion is flagged, then pin low the same cycle
  property p_autoSet;
    @(posedge mclk) disable iff (!nrst)
    (mask_q[BIT_AUTO] && autoDone) |=> flags_q[BIT_AUTO] && !irqN;
  endproperty
  a_autoSet: assert property (p_autoSet) else $error("auto flag or pin missing"); // R3

  // buffer full is flagged even if a clear arrives in the same cycle
  property p_fifoSet;
    @(posedge mclk) disable iff (!nrst)
    (mask_q[BIT_FIFO] && bufferFull) |=> flags_q[BIT_FIFO];
  endproperty
  a_fifoSet: assert property (p_fifoSet) else $error("fifo flag not set"); // R4

  // overlay sequence end is flagged
  property p_osdSet;
    @(posedge mclk) disable iff (!nrst)
    (mask_q[BIT_OSD] && osdSeqEnd) |=> flags_q[BIT_OSD];
  endproperty
  a_osdSet: assert property (p_osdSet) else $error("osd flag not set"); // R5

  // output stream break is flagged
  property p_oifSet;
    @(posedge mclk) disable iff (!nrst)
    (mask_q[BIT_OIF] && oifBreak) |=> flags_q[BIT_OIF];
  endproperty
  a_oifSet: assert property (p_oifSet) else $error("oif flag not set"); // R6

  // jitter level over threshold sets the iif flag
  property p_iifSet;
    @(posedge mclk) disable iff (!nrst)
    (mask_q[BIT_IIF] && jitterEvent) |=> flags_q[BIT_IIF];
  endproperty
  a_iifSet: assert property (p_iifSet) else $error("iif flag not set"); // R7

  // status read returns the flags held one cycle earlier
  property p_readStatus;
    @(posedge mclk) disable iff (!nrst)
    (cfgAddr == ADDR_IRQ_STATUS) |=> (cfgRdData == {2'h0, $past(flags_q)});
  endproperty
  a_readStatus: assert property (p_readStatus) else $error("status read mismatch"); // R8

  // a set flag holds while no one is written to it
  property p_sticky;
    @(posedge mclk) disable iff (!nrst)
    flags_q[BIT_OSD] ##0 s_noClear(BIT_OSD) |=> flags_q[BIT_OSD];
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag dropped without a clear"); // R9

  // writing one with no new event clears the flag
  property p_clear;
    @(posedge mclk) disable iff (!nrst)
    s_statusWriteOnes(BIT_AUTO) ##0 !setVec[BIT_AUTO] |=> !flags_q[BIT_AUTO];
  endproperty
  a_clear: assert property (p_clear) else $error("write one did not clear flag"); // R9

  // mask write lands in the mask register
  property p_maskWrite;
    @(posedge mclk) disable iff (!nrst)
    wrMask |=> (mask_q == $past(cfgWrData[FLAG_COUNT-1:0]));
  endproperty
  a_maskWrite: assert property (p_maskWrite) else $error("mask write lost"); // R10

  // disabled condition leaves a clear flag clear
  property p_maskGate;
    @(posedge mclk) disable iff (!nrst)
    (!mask_q[BIT_FIFO] && !flags_q[BIT_FIFO]) |=> !flags_q[BIT_FIFO];
  endproperty
  a_maskGate: assert property (p_maskGate) else $error("masked condition set its flag"); // R12

  // an event arriving in the clearing cycle keeps its flag
  property p_setWins;
    @(posedge mclk) disable iff (!nrst)
    s_statusWriteOnes(BIT_IIF) ##0 setVec[BIT_IIF] |=> flags_q[BIT_IIF];
  endproperty
  a_setWins: assert property (p_setWins) else $error("clear beat a same-cycle event"); // R9

  // masked conditions cannot pull the pin while no flag is up
  property p_pinQuiet;
    @(posedge mclk) disable iff (!nrst)
    (flags_q == '0) && ((cond & mask_q) == '0) |=> irqN;
  endproperty
  a_pinQuiet: assert property (p_pinQuiet) else $error("masked condition moved the irq pin"); // R12

  // mask only changes through its own write
  property p_maskHold;
    @(posedge mclk) disable iff (!nrst)
    !wrMask |=> $stable(mask_q);
  endproperty
  a_maskHold: assert property (p_maskHold) else $error("mask changed without a write"); // R10

  // mask reads back with the unused bits zero
  property p_readMask;
    @(posedge mclk) disable iff (!nrst)
    (cfgAddr == ADDR_IRQ_MASK) |=> (cfgRdData == {2'h0, $past(mask_q)});
  endproperty
  a_readMask: assert property (p_readMask) else $error("mask read mismatch"); // R10

  // unmapped addresses always read as zero
  property p_readUnmapped;
    @(posedge mclk) disable iff (!nrst)
    (cfgAddr != ADDR_IRQ_STATUS) && (cfgAddr != ADDR_IRQ_MASK) && (cfgAddr != ADDR_JITTER_TH)
      |=> (cfgRdData == 8'h00);
  endproperty
  a_readUnmapped: assert property (p_readUnmapped) else $error("unmapped read not zero"); // R8
endmodule

// [bench/sea_host_model.sv]
// host side model: owns the configuration port and watches the interrupt pin
// assumes the bench calls its tasks, and that every change lands at falling mclk
`timescale 1ns/1ps
module sea_host_model
(
  input  wire logic       mclk,
  input  wire logic       irqN,       // active-low interrupt pin
  input  wire logic [7:0] cfgRdData,  // registered read data
  output logic      [7:0] cfgAddr,    // register address
  output logic            cfgWrEn,    // one-cycle write strobe
  output logic      [7:0] cfgWrData,  // write data
  output int              irqFalls    // pin assertions seen by the host
);
  // quiet port at time zero
  initial
  begin
    cfgAddr   = 8'h00;
    cfgWrEn   = 1'h0;
    cfgWrData = 8'h00;
    irqFalls  = 0;
  end

  // a one in a status bit clears that flag, a zero leaves it alone
  task automatic wrReg(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    cfgAddr   = a;
    cfgWrData = d;
    cfgWrEn   = 1'h1;
    @(negedge mclk);
    cfgWrEn   = 1'h0;
    cfgWrData = ~d;  // stale data must not look like a fresh write
  endtask

  // read data trails the address by one edge, so sample one cycle later
  task automatic rdReg(input logic [7:0] a, output logic [7:0] d);
    @(negedge mclk);
    cfgAddr = a;
    @(negedge mclk);
    d = cfgRdData;
  endtask

  // each fall of the pin is one interrupt the host would service
  always @(negedge irqN)
    irqFalls <= irqFalls + 1;
endmodule

// [bench/tb_top.sv]
// self-checking bench for the status event aggregator
// assumes the host model owns the register port; events change at falling mclk
`timescale 1ns/1ps
module tb_top;
  import sea_pkg::*;
  logic       mclk;         // 50 MHz clock
  logic       nrst;         // async reset, active low
  logic [7:0] cfgAddr;      // from host model
  logic       cfgWrEn;      // from host model
  logic [7:0] cfgWrData;    // from host model
  logic [7:0] cfgRdData;    // read data
  logic [3:0] modeCause;    // mode causes
  logic [3:0] modeCauseEn;  // mode cause enables
  logic       autoDone;     // sub-unit events
  logic       bufferFull;
  logic       osdSeqEnd;
  logic       oifBreak;
  logic       hsyncPulse;   // line start
  logic       vsyncPulse;   // frame start
  logic       inWindow;     // sampled area
  logic       detectAll;    // detect everywhere
  logic       irqN;         // interrupt pin
  int         irqFalls;     // pin assertions counted by host
  int         errCount;     // mismatches
  int         nCompared;    // comparisons

  sea_status_event_aggregator #(.JIT_CNT_W(8)) sea_status_event_aggregator_i
  (
    .mclk(mclk), .nrst(nrst), .cfgAddr(cfgAddr), .cfgWrEn(cfgWrEn), .cfgWrData(cfgWrData),
    .cfgRdData(cfgRdData), .modeCause(modeCause), .modeCauseEn(modeCauseEn), .autoDone(autoDone),
    .bufferFull(bufferFull), .osdSeqEnd(osdSeqEnd), .oifBreak(oifBreak), .hsyncPulse(hsyncPulse),
    .vsyncPulse(vsyncPulse), .inWindow(inWindow), .detectAll(detectAll), .irqN(irqN)
  );

  sea_host_model sea_host_model_i
  (
    .mclk(mclk), .irqN(irqN), .cfgRdData(cfgRdData), .cfgAddr(cfgAddr),
    .cfgWrEn(cfgWrEn), .cfgWrData(cfgWrData), .irqFalls(irqFalls)
  );

  // free-running clock
  initial
  begin
    mclk = 1'h0;
    forever #10 mclk = ~mclk;
  end

  // value compare, four-state exact
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    nCompared++;
    if (got !== exp)
    begin
      errCount++;
      $display("[FAIL] %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic chkReg(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    sea_host_model_i.rdReg(a, d);
    chk(d, exp, "register");
  endtask

  // pin is registered, let one more edge land first
  task automatic chkIrq(input logic exp);
    @(negedge mclk);
    chk({7'h00, irqN}, {7'h00, exp}, "irq pin");
  endtask

  // one-cycle event on source b; mode uses the cause vector c
  task automatic fire(input int b, input logic [3:0] c);
    @(negedge mclk);
    modeCause  = (b == BIT_MODE) ? c : 4'h0;
    autoDone   = (b == BIT_AUTO);
    bufferFull = (b == BIT_FIFO);
    osdSeqEnd  = (b == BIT_OSD);
    oifBreak   = (b == BIT_OIF);
    @(negedge mclk);
    {modeCause, autoDone, bufferFull, osdSeqEnd, oifBreak} = 8'h00;
    @(negedge mclk);
  endtask

  // hsync pulse n cycles after the previous one
  task automatic hs(input int n);
    repeat (n - 1) @(negedge mclk);
    hsyncPulse = 1'h1;
    @(negedge mclk);
    hsyncPulse = 1'h0;
  endtask

  task automatic vs();
    @(negedge mclk);
    vsyncPulse = 1'h1;
    @(negedge mclk);
    vsyncPulse = 1'h0;
  endtask

  task automatic conclude();
    $display("compared %0d mismatches %0d", nCompared, errCount);
    if (errCount == 0 && nCompared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // hang guard: a bounded run, long past the real sequence
  initial
  begin
    repeat (20000) @(posedge mclk);
    errCount++;
    $display("[FAIL] %0t run did not finish", $time);
    conclude();
  end

  // main sequence
  initial
  begin
    errCount = 0;
    nCompared = 0;
    nrst = 1'h0;
    {modeCause, autoDone, bufferFull, osdSeqEnd, oifBreak} = 8'h00;
    {hsyncPulse, vsyncPulse, inWindow, detectAll} = 4'h0;
    modeCauseEn = 4'hF;
    repeat (3) @(negedge mclk);
    nrst = 1'h1;
    chkIrq(1'h1);
    chkReg(ADDR_IRQ_MASK, 8'h00);
    chkReg(ADDR_IRQ_STATUS, 8'h00);
    sea_host_model_i.wrReg(8'h10, 8'hFF);
    chkReg(8'h10, 8'h00);
    $display("test reset done");
    // the five sources mode to oif fire while masked: nothing may stick
    for (int b = 0; b < 5; b++)
      fire(b, 4'hF);
    chkReg(ADDR_IRQ_STATUS, 8'h00);
    chkIrq(1'h1);
    sea_host_model_i.wrReg(ADDR_IRQ_MASK, 8'hFF);
    chkReg(ADDR_IRQ_MASK, 8'h3F);
    $display("test mask done");
    // each of the sources mode to oif sets only its own sticky flag
    for (int b = 0; b < 5; b++)
    begin
      fire(b, 4'h1);
      chkIrq(1'h0);
      chkReg(ADDR_IRQ_STATUS, 8'h01 << b);
      sea_host_model_i.wrReg(ADDR_IRQ_STATUS, ~(8'h01 << b));
      chkReg(ADDR_IRQ_STATUS, 8'h01 << b);
      sea_host_model_i.wrReg(ADDR_IRQ_STATUS, 8'h01 << b);
      chkReg(ADDR_IRQ_STATUS, 8'h00);
      chkIrq(1'h1);
    end
    // every mode cause, gated by its own enable
    for (int c = 0; c < MODE_CAUSES; c++)
    begin
      modeCauseEn = ~(4'h1 << c);
      fire(BIT_MODE, 4'h1 << c);
      chkReg(ADDR_IRQ_STATUS, 8'h00);
      modeCauseEn = 4'h1 << c;
      fire(BIT_MODE, 4'h1 << c);
      chkReg(ADDR_IRQ_STATUS, 8'h01);
      sea_host_model_i.wrReg(ADDR_IRQ_STATUS, 8'h01);
    end
    // pin stays low while any flag remains
    fire(BIT_AUTO, 4'h0);
    fire(BIT_OSD, 4'h0);
    sea_host_model_i.wrReg(ADDR_IRQ_STATUS, 8'h02);
    chkIrq(1'h0);
    sea_host_model_i.wrReg(ADDR_IRQ_STATUS, 8'h08);
    chkIrq(1'h1);
    $display("test events done");
    // jitter: threshold one, lines outside the window are not counted
    sea_host_model_i.wrReg(ADDR_IRQ_MASK, 8'h20);
    sea_host_model_i.wrReg(ADDR_JITTER_TH, 8'h01);
    chkReg(ADDR_JITTER_TH, 8'h01);
    vs();
    hs(10);
    hs(11);
    hs(10);
    inWindow = 1'h1;
    hs(14);
    hs(11);
    repeat (3) @(negedge mclk);
    chkIrq(1'h1);
    hs(6);
    repeat (3) @(negedge mclk);
    chkIrq(1'h0);
    // level re-sets the flag until the next frame
    sea_host_model_i.wrReg(ADDR_IRQ_STATUS, 8'h20);
    chkReg(ADDR_IRQ_STATUS, 8'h20);
    vs();
    repeat (3) @(negedge mclk);
    sea_host_model_i.wrReg(ADDR_IRQ_STATUS, 8'h20);
    chkReg(ADDR_IRQ_STATUS, 8'h00);
    chkIrq(1'h1);
    // detect-all counts lines outside the window too
    inWindow  = 1'h0;
    detectAll = 1'h1;
    sea_host_model_i.wrReg(ADDR_JITTER_TH, 8'h00);
    vs();
    hs(10);
    hs(10);
    repeat (3) @(negedge mclk);
    chkReg(ADDR_IRQ_STATUS, 8'h00);
    hs(11);
    repeat (3) @(negedge mclk);
    chkReg(ADDR_IRQ_STATUS, 8'h20);
    vs();
    repeat (3) @(negedge mclk);
    sea_host_model_i.wrReg(ADDR_IRQ_STATUS, 8'h20);
    chkReg(ADDR_IRQ_STATUS, 8'h00);
    chkIrq(1'h1);
    chk(irqFalls[7:0], 8'h0C, "irq count");
    $display("test jitter done");
    conclude();
  end
endmodule
